// ---- logic/radio_agc_pa_defines.vh ----
// register offsets, field positions and reset values for the agc / pa config block
// assumes inclusion by bare name from the design files under logic/
// Contract
// - deadband code 00 small, 11 largest zone
// - settle 8/16/24/32 samples after gain step
// - hold 00: adjust gain whenever needed
// - hold 01: freeze gain after sync word
// - hold 10: analog fixed, digital adjusts
// - hold 11: both gains fixed, manual override
// - averaging span 8/16/32/64 samples
// - averaging span also sets ask slicer boundary
// - power index picks one of eight entries
// - ask one uses index, zero uses entry 0
// - ramp and shaping step entries 0..index
// - four rx bias trims driven to front end
// - tx lo trim resets to 01, driven out
`ifndef RADIO_AGC_PA_DEFINES_VH
`define RADIO_AGC_PA_DEFINES_VH
`define AGC_TUNING_IDX        16'hDF19
`define RX_FRONT_END_BIAS_IDX 16'hDF1A
`define TX_FRONT_END_CFG_IDX  16'hDF1B
`define PTAB_BASE_IDX         16'hDF20
`define RAMP_CTRL_IDX         16'hDF28
`define AGC_TUNING_RST        8'h91
`define RX_FRONT_END_BIAS_RST 8'h56
`define TX_FRONT_END_CFG_RST  8'h10
`define TX_FRONT_END_CFG_MASK 8'h37
`define PTAB_RST              8'h00
`define RAMP_CTRL_RST         8'h04
`define DEADBAND_MSB          7
`define DEADBAND_LSB          6
`define SETTLE_MSB            5
`define SETTLE_LSB            4
`define HOLD_MSB              3
`define HOLD_LSB              2
`define SPAN_MSB              1
`define SPAN_LSB              0
`define PIDX_MSB              2
`define PIDX_LSB              0
`define TXLO_MSB              5
`define TXLO_LSB              4
`endif

// ---- logic/power_ramp_stepper.v ----
// steps the power table index between 0 and a target, one step per enable pulse
// assumes step_en is a one-cycle pulse on clock
`timescale 1ns/1ns
module power_ramp_stepper (
  clock,
  srst,
  step_en,
  target,
  up,
  level,
  at_top,
  at_zero
);
  input  wire       clock;
  input  wire       srst;
  input  wire       step_en;
  input  wire [2:0] target;
  input  wire       up;
  output wire [2:0] level;
  output wire       at_top;
  output wire       at_zero;

  reg [2:0] level_q;
  assign level   = level_q;
  assign at_top  = (level_q == target);
  assign at_zero = (level_q == 3'h0);

  always @(posedge clock) begin
    if (srst) begin
      level_q <= 3'h0;
    end else if (step_en) begin
      // up steps never pass target; entries above it are only walked down from
      // a lowered target is walked down one entry at a time, never jumped to
      if (up && level_q < target)
        level_q <= level_q + 3'h1;
      else if (level_q != 3'h0 && (!up || level_q > target))
        level_q <= level_q - 3'h1;
    end
  end
endmodule // power_ramp_stepper

// ---- logic/radio_agc_pa_config.v ----
// agc and pa configuration registers with avalon-mm slave, agc gain policy
// and power_table_index level selection with ramp/ask shaping
// assumes radio datapath strobes arrive on clock; pins listed are synchronised
`timescale 1ns/1ns
`include "radio_agc_pa_defines.vh"
module radio_agc_pa_config #(
  parameter ADDR_W = 18,
  parameter RAMP_DIV = 16
) (
  clock,
  srst,
  address,
  read,
  write,
  writedata,
  byteenable,
  readdata,
  readdatavalid_unused,
  waitrequest,
  response,
  sample_strobe,
  agc_want_step,
  sync_found,
  rx_active,
  ask_mode,
  tx_active,
  tx_symbol,
  analog_gain_step,
  digital_gain_step,
  agc_accumulate,
  deadband_select,
  avg_span_samples,
  slice_boundary_len,
  lna_bias_trim,
  lna_to_mixer_bias_trim,
  rx_lo_buffer_trim,
  mixer_bias_trim,
  tx_lo_buffer_trim,
  pa_setting,
  pa_level_index,
  tx_ramp_done
);
  input  wire [ADDR_W-1:0] address;
  input  wire              clock;
  input  wire              srst;
  input  wire              read;
  input  wire              write;
  input  wire [31:0]       writedata;
  input  wire [3:0]        byteenable;
  output reg  [31:0]       readdata;
  output wire              readdatavalid_unused;
  output wire              waitrequest;
  output reg  [1:0]        response;
  input  wire              sample_strobe;
  input  wire              agc_want_step;
  input  wire              sync_found;
  input  wire              rx_active;
  input  wire              ask_mode;
  input  wire              tx_active;
  input  wire              tx_symbol;
  output reg               analog_gain_step;
  output reg               digital_gain_step;
  output reg               agc_accumulate;
  output reg  [1:0]        deadband_select;
  output reg  [6:0]        avg_span_samples;
  output reg  [6:0]        slice_boundary_len;
  output reg  [1:0]        lna_bias_trim;
  output reg  [1:0]        lna_to_mixer_bias_trim;
  output reg  [1:0]        rx_lo_buffer_trim;
  output reg  [1:0]        mixer_bias_trim;
  output reg  [1:0]        tx_lo_buffer_trim;
  output reg  [7:0]        pa_setting;
  output reg  [2:0]        pa_level_index;
  output wire              tx_ramp_done;

  localparam [1:0] HOLD_NONE = 2'h0;
  localparam [1:0] HOLD_SYNC = 2'h1;
  localparam [1:0] HOLD_ANLG = 2'h2;
  localparam [1:0] HOLD_BOTH = 2'h3;

  localparam [2:0] ST_ACCUM  = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_FROZEN = 3'h4;

  reg [7:0] agc_tuning_q;
  reg [7:0] rx_front_end_bias_q;
  reg [7:0] tx_front_end_config_q;
  reg [7:0] ramp_ctrl_q;
  reg [7:0] power_setting_table_q [0:7];

  // one wait cycle: request held one extra edge so every access answers in 2
  reg  pend_q;
  wire req = read | write;
  assign waitrequest = req & ~pend_q;
  // fixed-latency slave, so the pipelined valid strobe is never used
  assign readdatavalid_unused = 1'b0;

  wire [15:0] word_idx = address[17:2];
  wire hit_agc  = (word_idx == `AGC_TUNING_IDX);
  wire hit_rxb  = (word_idx == `RX_FRONT_END_BIAS_IDX);
  wire hit_txc  = (word_idx == `TX_FRONT_END_CFG_IDX);
  wire hit_ramp = (word_idx == `RAMP_CTRL_IDX);
  // table decode on the upper index bits: eight consecutive words
  wire [15:0] ptab_base = `PTAB_BASE_IDX;
  wire hit_tab  = (word_idx[15:3] == ptab_base[15:3]);
  wire hit_any  = hit_agc | hit_rxb | hit_txc | hit_ramp | hit_tab;
  wire do_wr    = write & pend_q & byteenable[0];
  wire [7:0] wd = writedata[7:0];

  integer i;
  always @(posedge clock) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= req & ~pend_q;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      agc_tuning_q          <= `AGC_TUNING_RST;
      rx_front_end_bias_q   <= `RX_FRONT_END_BIAS_RST;
      tx_front_end_config_q <= `TX_FRONT_END_CFG_RST;
      ramp_ctrl_q           <= `RAMP_CTRL_RST;
      for (i = 0; i < 8; i = i + 1)
        power_setting_table_q[i] <= `PTAB_RST;
    end else if (do_wr) begin
      if (hit_agc)
        agc_tuning_q <= wd;
      if (hit_rxb)
        rx_front_end_bias_q <= wd;
      if (hit_txc)
        tx_front_end_config_q <= wd & `TX_FRONT_END_CFG_MASK;
      if (hit_ramp)
        ramp_ctrl_q <= wd;
      if (hit_tab)
        power_setting_table_q[word_idx[2:0]] <= wd;
    end
  end

  // response 10 flags an unmapped word; writes there are dropped
  always @(posedge clock) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if (read & ~pend_q) begin
      response <= hit_any ? 2'h0 : 2'h2;
      if (hit_agc)
        readdata <= {24'h00_0000, agc_tuning_q};
      else if (hit_rxb)
        readdata <= {24'h00_0000, rx_front_end_bias_q};
      else if (hit_txc)
        readdata <= {24'h00_0000, tx_front_end_config_q};
      else if (hit_ramp)
        readdata <= {24'h00_0000, ramp_ctrl_q};
      else if (hit_tab)
        readdata <= {24'h00_0000, power_setting_table_q[word_idx[2:0]]};
      else
        readdata <= 32'h0000_0000;
    end else if (write & ~pend_q) begin
      response <= hit_any ? 2'h0 : 2'h2;
    end
  end

  wire [1:0] hold_mode = agc_tuning_q[`HOLD_MSB:`HOLD_LSB];
  wire [1:0] settle    = agc_tuning_q[`SETTLE_MSB:`SETTLE_LSB];
  wire [1:0] span      = agc_tuning_q[`SPAN_MSB:`SPAN_LSB];

  // settle count: 8*(code+1) samples
  wire [5:0] settle_len = {1'b0, settle, 3'h0} + 6'h08;
  reg  [5:0] settle_cnt_q;
  reg  [2:0] agc_state_q;
  reg        synced_q;

  // sync latch clears when the receiver drops, ready for the next packet
  always @(posedge clock) begin
    if (srst) begin
      synced_q <= 1'b0;
    end else if (!rx_active) begin
      synced_q <= 1'b0;
    end else if (sync_found) begin
      synced_q <= 1'b1;
    end
  end

  wire analog_ok  = (hold_mode == HOLD_NONE) ||
                    (hold_mode == HOLD_SYNC && !synced_q);
  wire digital_ok = analog_ok || (hold_mode == HOLD_ANLG);
  wire frozen     = !digital_ok;

  always @(posedge clock) begin
    if (srst) begin
      agc_state_q       <= ST_ACCUM;
      settle_cnt_q      <= 6'h00;
      analog_gain_step  <= 1'b0;
      digital_gain_step <= 1'b0;
      agc_accumulate    <= 1'b0;
    end else begin
      analog_gain_step  <= 1'b0;
      digital_gain_step <= 1'b0;
      agc_accumulate    <= 1'b0;
      case (agc_state_q)
        ST_ACCUM: begin
          if (frozen) begin
            agc_state_q <= ST_FROZEN;
          end else if (sample_strobe && rx_active) begin
            if (agc_want_step) begin
              analog_gain_step  <= analog_ok;
              digital_gain_step <= ~analog_ok;
              settle_cnt_q      <= settle_len;
              agc_state_q       <= ST_SETTLE;
            end else begin
              agc_accumulate <= 1'b1;
            end
          end
        end
        ST_SETTLE: begin
          // no accumulation until the settle window has passed
          if (sample_strobe) begin
            if (settle_cnt_q == 6'h01)
              agc_state_q <= ST_ACCUM;
            settle_cnt_q <= settle_cnt_q - 6'h01;
          end
        end
        ST_FROZEN: begin
          // hold 11, or hold 01 after sync: gain untouched, samples still averaged
          if (!frozen)
            agc_state_q <= ST_ACCUM;
          else if (sample_strobe && rx_active)
            agc_accumulate <= 1'b1;
        end
        default: agc_state_q <= ST_ACCUM;
      endcase
    end
  end

  // outputs lag the registers by one cycle; the analog side treats them as static
  always @(posedge clock) begin
    if (srst) begin
      deadband_select        <= 2'h2;
      avg_span_samples       <= 7'h10;
      slice_boundary_len     <= 7'h10;
      lna_bias_trim          <= 2'h1;
      lna_to_mixer_bias_trim <= 2'h1;
      rx_lo_buffer_trim      <= 2'h1;
      mixer_bias_trim        <= 2'h2;
      tx_lo_buffer_trim      <= 2'h1;
    end else begin
      deadband_select    <= agc_tuning_q[`DEADBAND_MSB:`DEADBAND_LSB];
      avg_span_samples   <= 7'h08 << span;
      slice_boundary_len <= 7'h08 << span;
      lna_bias_trim          <= rx_front_end_bias_q[7:6];
      lna_to_mixer_bias_trim <= rx_front_end_bias_q[5:4];
      rx_lo_buffer_trim      <= rx_front_end_bias_q[3:2];
      mixer_bias_trim        <= rx_front_end_bias_q[1:0];
      tx_lo_buffer_trim      <= tx_front_end_config_q[`TXLO_MSB:`TXLO_LSB];
    end
  end

  // ramp step pacing; divider length from ramp_ctrl, minimum one cycle
  wire [2:0] power_index = tx_front_end_config_q[`PIDX_MSB:`PIDX_LSB];
  reg  [7:0] div_q;
  wire       step_en = (div_q == 8'h00);
  always @(posedge clock) begin
    if (srst)
      div_q <= 8'h00;
    else if (step_en)
      div_q <= ramp_ctrl_q;
    else
      div_q <= div_q - 8'h01;
  end

  // ask: ramp toward index on one, toward zero on zero
  wire ramp_up = tx_active && (!ask_mode || tx_symbol);
  wire [2:0] level;
  wire at_top;
  wire at_zero;
  power_ramp_stepper u_ramp (
    .clock   (clock),
    .srst    (srst),
    .step_en (step_en),
    .target  (power_index),
    .up      (ramp_up),
    .level   (level),
    .at_top  (at_top),
    .at_zero (at_zero)
  );
  assign tx_ramp_done = tx_active ? at_top : at_zero;

  // index and setting change together so the pa never sees a mixed pair
  always @(posedge clock) begin
    if (srst) begin
      pa_setting     <= 8'h00;
      pa_level_index <= 3'h0;
    end else begin
      pa_level_index <= level;
      pa_setting     <= power_setting_table_q[level];
    end
  end
endmodule // radio_agc_pa_config

// ---- sim/radio_agc_pa_monitor.sv ----
// port-level assertions for the agc / pa configuration block
// assumes a bind onto radio_agc_pa_config, one clock, synchronous reset
`timescale 1ns/1ns
`include "radio_agc_pa_defines.vh"
module radio_agc_pa_monitor #(
  parameter ADDR_W = 18
) (
  input wire [ADDR_W-1:0] address,
  input wire              clock,
  input wire              srst,
  input wire              read,
  input wire              write,
  input wire [31:0]       writedata,
  input wire [3:0]        byteenable,
  input wire [31:0]       readdata,
  input wire              waitrequest,
  input wire              sample_strobe,
  input wire              agc_want_step,
  input wire              analog_gain_step,
  input wire              digital_gain_step,
  input wire              agc_accumulate,
  input wire [1:0]        deadband_select,
  input wire [6:0]        avg_span_samples,
  input wire [6:0]        slice_boundary_len,
  input wire [1:0]        lna_bias_trim,
  input wire [1:0]        lna_to_mixer_bias_trim,
  input wire [1:0]        rx_lo_buffer_trim,
  input wire [1:0]        mixer_bias_trim,
  input wire [1:0]        tx_lo_buffer_trim,
  input wire [2:0]        pa_level_index
);
  localparam [ADDR_W-1:0] A_AGC = `AGC_TUNING_IDX * 4;
  localparam [ADDR_W-1:0] A_RX = `RX_FRONT_END_BIAS_IDX * 4;
  localparam [ADDR_W-1:0] A_TX = `TX_FRONT_END_CFG_IDX * 4;
  // a write lands on the edge where waitrequest is seen low
  wire wr_ok = write && !waitrequest && byteenable[0];
  wire step  = analog_gain_step || digital_gain_step;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  AST_DEADBAND: assert property (
    wr_ok && address == A_AGC |=> ##1 deadband_select == $past(writedata[7:6], 2))
    else $error("deadband output wrong");
  AST_SETTLE_QUIET: assert property (step |=> !agc_accumulate [*8])
    else $error("accumulation during settling");
  AST_STEP_CAUSE: assert property (
    step |-> $past(sample_strobe && agc_want_step))
    else $error("gain step without request");
  AST_SPAN: assert property (
    wr_ok && address == A_AGC |=> ##1 avg_span_samples == (7'h08 << $past(writedata[1:0], 2)))
    else $error("averaging span wrong");
  AST_SLICE: assert property (slice_boundary_len == avg_span_samples)
    else $error("slicer span differs");
  AST_LEVEL_STEP: assert property (
    pa_level_index != $past(pa_level_index) |->
      pa_level_index - $past(pa_level_index) == 3'h1 ||
      $past(pa_level_index) - pa_level_index == 3'h1)
    else $error("power level jumped");
  AST_RX_TRIMS: assert property (
    wr_ok && address == A_RX |=> ##1 {lna_bias_trim, lna_to_mixer_bias_trim,
      rx_lo_buffer_trim, mixer_bias_trim} == $past(writedata[7:0], 2))
    else $error("rx trims wrong");
  AST_TX_TRIM: assert property (
    wr_ok && address == A_TX |=> ##1 tx_lo_buffer_trim == $past(writedata[5:4], 2))
    else $error("tx trim wrong");
  AST_TX_UNUSED: assert property (
    read && !waitrequest && address == A_TX |-> readdata[7:6] == 2'h0 && !readdata[3])
    else $error("unused tx bits not zero");
endmodule // radio_agc_pa_monitor

bind radio_agc_pa_config radio_agc_pa_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .address(address), .clock(clock), .srst(srst), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .sample_strobe(sample_strobe), .agc_want_step(agc_want_step),
  .analog_gain_step(analog_gain_step), .digital_gain_step(digital_gain_step),
  .agc_accumulate(agc_accumulate), .deadband_select(deadband_select),
  .avg_span_samples(avg_span_samples), .slice_boundary_len(slice_boundary_len),
  .lna_bias_trim(lna_bias_trim), .lna_to_mixer_bias_trim(lna_to_mixer_bias_trim),
  .rx_lo_buffer_trim(rx_lo_buffer_trim), .mixer_bias_trim(mixer_bias_trim),
  .tx_lo_buffer_trim(tx_lo_buffer_trim), .pa_level_index(pa_level_index));

// ---- sim/radio_agc_pa_config_tb.sv ----
// self-checking bench for the agc / pa configuration block
// assumes avalon-mm slave with one wait cycle, bench drives all ports
`timescale 1ns/1ns
`include "radio_agc_pa_defines.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module radio_agc_pa_config_tb;
  reg         clock, srst, read, write, sample_strobe, agc_want_step, sync_found;
  reg         rx_active, ask_mode, tx_active, tx_symbol;
  reg  [17:0] address;
  reg  [31:0] writedata;
  reg  [3:0]  byteenable;
  reg  [1:0]  last_resp;
  reg  [7:0]  q;
  wire [31:0] readdata;
  wire        waitrequest, analog_gain_step, digital_gain_step, agc_accumulate;
  wire [1:0]  response, deadband_select, lna_bias_trim, lna_to_mixer_bias_trim;
  wire [1:0]  rx_lo_buffer_trim, mixer_bias_trim, tx_lo_buffer_trim;
  wire [6:0]  avg_span_samples, slice_boundary_len;
  wire [7:0]  pa_setting;
  wire [2:0]  pa_level_index;
  wire        ramp_done;
  integer     error_cnt = 0, check_count = 0, i, na, nd, gap;

  radio_agc_pa_config i_dut (
    .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .readdatavalid_unused(), .waitrequest(waitrequest), .response(response),
    .sample_strobe(sample_strobe), .agc_want_step(agc_want_step), .sync_found(sync_found),
    .rx_active(rx_active), .ask_mode(ask_mode), .tx_active(tx_active),
    .tx_symbol(tx_symbol), .analog_gain_step(analog_gain_step),
    .digital_gain_step(digital_gain_step), .agc_accumulate(agc_accumulate),
    .deadband_select(deadband_select), .avg_span_samples(avg_span_samples),
    .slice_boundary_len(slice_boundary_len), .lna_bias_trim(lna_bias_trim),
    .lna_to_mixer_bias_trim(lna_to_mixer_bias_trim), .rx_lo_buffer_trim(rx_lo_buffer_trim),
    .mixer_bias_trim(mixer_bias_trim), .tx_lo_buffer_trim(tx_lo_buffer_trim),
    .pa_setting(pa_setting), .pa_level_index(pa_level_index), .tx_ramp_done(ramp_done));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one access, held until waitrequest is seen low, then three idle edges
  task automatic bus(input [15:0] idx, input w, input [7:0] d, input [3:0] be);
    integer n;
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h000000, d};
    byteenable <= be;
    n = 0;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n = n + 1;
    end
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      test_done;
    end
    q = readdata[7:0];
    last_resp = response;
    read <= 1'b0;
    write <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // strobes every third cycle; gap counts strobes between two gain steps
  task automatic agc_run(input integer n);
    integer k, first;
    na = 0;
    nd = 0;
    gap = -1;
    first = -1;
    for (k = 0; k < n; k = k + 1) begin
      sample_strobe <= 1'b1;
      @(posedge clock);
      sample_strobe <= 1'b0;
      repeat (2) begin
        @(posedge clock);
        na = na + (analog_gain_step === 1'b1);
        nd = nd + (digital_gain_step === 1'b1);
        if ((analog_gain_step | digital_gain_step) === 1'b1) begin
          if (first < 0) first = k;
          else if (gap < 0) gap = k - first;
        end
      end
    end
  endtask

  task automatic wait_lvl(input [2:0] lv, input [7:0] ps, input dn);
    integer n;
    n = 0;
    while (pa_level_index !== lv && n < 100) begin
      @(posedge clock);
      n = n + 1;
    end
    if (pa_level_index !== lv) begin
      error_cnt++;
      test_done;
    end
    repeat (2) @(posedge clock);
    `CHK("pa_setting", ps, pa_setting);
    `CHK("ramp done", dn, ramp_done);
  endtask

  initial begin
    {srst, read, write, sync_found, ask_mode, tx_active, tx_symbol} = 7'h40;
    {sample_strobe, agc_want_step, rx_active} = 3'h0;
    address = 18'h00000;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK("deadband rst", 2'h2, deadband_select);
    `CHK("span rst", 7'h10, avg_span_samples);
    `CHK("rx trims rst", 8'h56, {lna_bias_trim, lna_to_mixer_bias_trim,
      rx_lo_buffer_trim, mixer_bias_trim});
    `CHK("tx trim rst", 2'h1, tx_lo_buffer_trim);
    bus(`AGC_TUNING_IDX, 1'b0, 8'h00, 4'hF);
    `CHK("agc_tuning rst", 8'h91, q);
    bus(`TX_FRONT_END_CFG_IDX, 1'b0, 8'h00, 4'hF);
    `CHK("tx cfg rst", 8'h10, q);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      bus(`AGC_TUNING_IDX, 1'b1, 8'h55 * i, 4'hF);
      `CHK("deadband", i[1:0], deadband_select);
      `CHK("span", 7'h08 << i, avg_span_samples);
      `CHK("slice", 7'h08 << i, slice_boundary_len);
    end
    bus(`RX_FRONT_END_BIAS_IDX, 1'b1, 8'hE4, 4'hF);
    bus(`RX_FRONT_END_BIAS_IDX, 1'b0, 8'h00, 4'hF);
    `CHK("rx bias", 8'hE4, q);
    bus(`TX_FRONT_END_CFG_IDX, 1'b1, 8'hFF, 4'hF);
    `CHK("tx trim", 2'h3, tx_lo_buffer_trim);
    bus(`TX_FRONT_END_CFG_IDX, 1'b1, 8'h00, 4'h0);
    bus(`TX_FRONT_END_CFG_IDX, 1'b0, 8'h00, 4'hF);
    `CHK("tx cfg", 8'h37, q);
    bus(16'h0100, 1'b0, 8'h00, 4'hF);
    `CHK("unmapped data", 8'h00, q);
    `CHK("unmapped resp", 2'h2, last_resp);
    $display("test registers done");
    agc_want_step <= 1'b1;
    rx_active <= 1'b1;
    for (i = 0; i < 4; i = i + 3) begin
      bus(`AGC_TUNING_IDX, 1'b1, i << 4, 4'hF);
      agc_run(80);
      `CHK("settle gap", 8 * (i + 1) + 1, gap);
    end
    bus(`AGC_TUNING_IDX, 1'b1, 8'h08, 4'hF);
    agc_run(30);
    `CHK("hold10 analog", 0, na);
    `CHK("hold10 digital", 1'b1, nd > 0);
    bus(`AGC_TUNING_IDX, 1'b1, 8'h0C, 4'hF);
    agc_run(30);
    `CHK("hold11 steps", 0, na + nd);
    bus(`AGC_TUNING_IDX, 1'b1, 8'h04, 4'hF);
    agc_run(30);
    `CHK("hold01 before sync", 1'b1, na + nd > 0);
    sync_found <= 1'b1;
    @(posedge clock);
    sync_found <= 1'b0;
    agc_run(30);
    `CHK("hold01 after sync", 0, na + nd);
    bus(`AGC_TUNING_IDX, 1'b1, 8'h00, 4'hF);
    agc_run(30);
    `CHK("hold00 steps", 1'b1, na + nd > 0);
    agc_want_step <= 1'b0;
    $display("test agc done");
    for (i = 0; i < 8; i = i + 1) bus(`PTAB_BASE_IDX + i, 1'b1, 8'hA0 + i, 4'hF);
    bus(`RAMP_CTRL_IDX, 1'b1, 8'h00, 4'hF);
    bus(`TX_FRONT_END_CFG_IDX, 1'b1, 8'h15, 4'hF);
    tx_symbol <= 1'b1;
    tx_active <= 1'b1;
    wait_lvl(3'h5, 8'hA5, 1'b1);
    ask_mode <= 1'b1;
    tx_symbol <= 1'b0;
    wait_lvl(3'h0, 8'hA0, 1'b0);
    tx_symbol <= 1'b1;
    wait_lvl(3'h5, 8'hA5, 1'b1);
    tx_active <= 1'b0;
    wait_lvl(3'h0, 8'hA0, 1'b1);
    bus(`TX_FRONT_END_CFG_IDX, 1'b1, 8'h07, 4'hF);
    tx_active <= 1'b1;
    wait_lvl(3'h7, 8'hA7, 1'b1);
    $display("test power done");
    test_done;
  end
endmodule // radio_agc_pa_config_tb
